// ==== rtl/ee_slave.v ====
// Two-wire serial EEPROM slave: selection, page writes, reads, timed programming
//
// Overview of operation
// RULE1: selection byte is type code b7-b4, chip bit b3, page b2-b1, direction b0.
// RULE2: answer only when selection b3 equals the chip address pin.
// RULE3: four pages of 256 bytes, page from selection, byte from address byte.
// RULE4: every byte moves most significant bit first.
// RULE5: write protect high and upper 512 addressed: no data ack, no store.
// RULE6: byte write and page write of up to eight bytes, one program cycle.
// RULE7: program cycle timed internally, or by external clock on time-control pin.
// RULE8: bytes stored with a code that corrects any single-bit error on read.
// RULE9: reset brings bus logic to idle within 10 microseconds.
// RULE10: internal cycle 7 ms; external clocking kept between 4 and 10 ms.
// RULE11: master keeps serial clock at or below 100 kHz; the bench master runs it at eight clocks per bit, 6.25 MHz.
// RULE12: selection byte not acknowledged while a program cycle runs.
`timescale 1ns/10ps
`include "ee_defines.vh"

module ee_slave #(
    parameter [19:0] T_INT_CYC = `EE_TEW_INT_US * `EE_CLK_MHZ,
    parameter [19:0] T_MIN_CYC = `EE_TEW_MIN_US * `EE_CLK_MHZ,
    parameter [19:0] T_MAX_CYC = `EE_TEW_MAX_US * `EE_CLK_MHZ
) (
    input wire CLK_I,
    input wire RST_B_I,
    input wire SCL_I,
    input wire SDA_I,
    output wire SDA_O,
    output wire SDA_OE_B_O,
    input wire WP_I,
    input wire CHIP_ADDR_PIN_I,
    input wire PROG_TIME_CTRL_I,
    output wire BUSY_O
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_SEL = 3'h1;
    localparam [2:0] ST_ADDR = 3'h2;
    localparam [2:0] ST_WR = 3'h3;
    localparam [2:0] ST_RD = 3'h4;

    localparam [1:0] EW_IDLE = 2'h0;
    localparam [1:0] EW_TIME = 2'h1;
    localparam [1:0] EW_COMMIT = 2'h2;

    reg [4:0] sync1;
    reg [4:0] sync2;
    reg [2:0] prev;
    reg [2:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] rx;
    reg [7:0] tx;
    reg [9:0] addr;
    reg ack_go;
    reg dev_tx;
    reg sda_oe_b;
    reg [7:0] valid;
    reg [7:0] wbuf [0:7];
    reg ew_req;
    reg [1:0] ew_state;
    reg [19:0] ew_cnt;
    reg [7:0] ptc_edges;
    reg ext_seen;
    reg [2:0] idx;
    reg busy;
    reg [11:0] mem [0:`EE_WORDS-1];

    wire scl_s = sync2[0];
    wire sda_s = sync2[1];
    wire ptc_s = sync2[2];
    wire wp_s = sync2[3];
    wire chip_s = sync2[4];
    wire scl_rise = scl_s & ~prev[0];
    wire scl_fall = ~scl_s & prev[0];
    wire start_cond = scl_s & prev[0] & ~sda_s & prev[1];
    wire stop_cond = scl_s & prev[0] & sda_s & ~prev[1];
    wire ptc_rise = ptc_s & ~prev[2];
    wire [7:0] next_rx = {rx[6:0], sda_s};
    wire [11:0] wr_code;
    wire [7:0] rd_byte;
    wire mem_we = (ew_state == EW_COMMIT) & valid[idx];
    wire ew_end;

    // Pins come from outside the clock domain: two flops, then an edge history
    always @(posedge CLK_I) begin
        if (!RST_B_I) begin
            sync1 <= 5'h1F;
            sync2 <= 5'h1F;
            prev <= 3'h7;
        end else begin
            sync1 <= {CHIP_ADDR_PIN_I, WP_I, PROG_TIME_CTRL_I, SDA_I, SCL_I};
            sync2 <= sync1;
            // RULE11: slow clock sampled
            prev <= sync2[2:0];
        end
    end

    // Bus engine; a start or stop anywhere overrides the frame in progress
    always @(posedge CLK_I) begin
        if (!RST_B_I) begin
            // RULE9: idle after reset
            state <= ST_IDLE;
            bit_cnt <= `EE_BIT_FIRST;
            rx <= 8'h00;
            tx <= 8'h00;
            addr <= 10'h000;
            ack_go <= 1'b0;
            dev_tx <= 1'b0;
            sda_oe_b <= 1'b1;
            valid <= 8'h00;
            ew_req <= 1'b0;
        end else begin
            ew_req <= 1'b0;
            if (start_cond) begin
                state <= ST_SEL;
                bit_cnt <= `EE_BIT_FIRST;
                dev_tx <= 1'b0;
                sda_oe_b <= 1'b1;
            end else if (stop_cond) begin
                // RULE6: one cycle for all
                if (state == ST_WR && valid != 8'h00) begin
                    ew_req <= 1'b1;
                end
                state <= ST_IDLE;
                dev_tx <= 1'b0;
                sda_oe_b <= 1'b1;
            end else if (state != ST_IDLE) begin
                if (scl_rise) begin
                    if (bit_cnt == `EE_BIT_ACK) begin
                        bit_cnt <= `EE_BIT_FIRST;
                        if (dev_tx) begin
                            // Master's not-acknowledge ends a read
                            if (sda_s) begin
                                state <= ST_IDLE;
                                dev_tx <= 1'b0;
                            end else begin
                                addr <= addr + 10'h001;
                            end
                        end else if (!ack_go) begin
                            state <= ST_IDLE;
                        end else begin
                            dev_tx <= (state == ST_RD);
                        end
                    end else begin
                        // RULE4: shift in from the top
                        rx <= next_rx;
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == `EE_BIT_LAST && !dev_tx) begin
                            case (state)
                                ST_SEL: begin
                                    // RULE1: split selection fields
                                    // RULE2: chip bit match
                                    // RULE12: busy means no ack
                                    if (next_rx[`EE_SEL_TYPE_HI:`EE_SEL_TYPE_LO] == `EE_DEV_TYPE
                                        && next_rx[`EE_SEL_CHIP] == chip_s && !busy) begin
                                        ack_go <= 1'b1;
                                        // RULE3: page from selection
                                        addr[`EE_PAGE_HI:`EE_PAGE_LO] <=
                                            next_rx[`EE_SEL_PAGE_HI:`EE_SEL_PAGE_LO];
                                        if (next_rx[`EE_SEL_RW]) begin
                                            state <= ST_RD;
                                        end else begin
                                            state <= ST_ADDR;
                                            valid <= 8'h00;
                                        end
                                    end else begin
                                        ack_go <= 1'b0;
                                        state <= ST_IDLE;
                                    end
                                end
                                ST_ADDR: begin
                                    // RULE3: byte within page
                                    addr[`EE_PAGE_LO-1:0] <= next_rx;
                                    ack_go <= 1'b1;
                                    state <= ST_WR;
                                end
                                ST_WR: begin
                                    // RULE5: protected upper half
                                    if (wp_s && addr[`EE_UPPER_BIT]) begin
                                        ack_go <= 1'b0;
                                    end else begin
                                        // RULE6: gather up to eight bytes
                                        wbuf[addr[`EE_SLOT_HI:0]] <= next_rx;
                                        valid[addr[`EE_SLOT_HI:0]] <= 1'b1;
                                        addr[`EE_SLOT_HI:0] <= addr[`EE_SLOT_HI:0] + 3'h1;
                                        ack_go <= 1'b1;
                                    end
                                end
                                default: begin
                                    ack_go <= 1'b0;
                                end
                            endcase
                        end
                    end
                end
                if (scl_fall) begin
                    if (bit_cnt == `EE_BIT_ACK) begin
                        // Pull low to acknowledge; release while master acks
                        sda_oe_b <= dev_tx | ~ack_go;
                    end else if (dev_tx && bit_cnt == `EE_BIT_FIRST) begin
                        // RULE4: send top bit first
                        sda_oe_b <= rd_byte[7];
                        tx <= {rd_byte[6:0], 1'b0};
                    end else if (dev_tx) begin
                        sda_oe_b <= tx[7];
                        tx <= {tx[6:0], 1'b0};
                    end else begin
                        sda_oe_b <= 1'b1;
                    end
                end
            end
        end
    end

    // RULE10: internal, min and max bounds
    assign ew_end = (!ext_seen && ew_cnt >= T_INT_CYC - 20'h00001)
                  | (ext_seen && ptc_edges >= `EE_PTC_EDGES
                     && ew_cnt >= T_MIN_CYC - 20'h00001)
                  | (ew_cnt >= T_MAX_CYC - 20'h00001);

    // Program cycle sequencer; bytes land in the array only after the timer
    always @(posedge CLK_I) begin
        if (!RST_B_I) begin
            ew_state <= EW_IDLE;
            ew_cnt <= 20'h00000;
            ptc_edges <= 8'h00;
            ext_seen <= 1'b0;
            idx <= 3'h0;
            busy <= 1'b0;
        end else begin
            case (ew_state)
                EW_IDLE: begin
                    if (ew_req) begin
                        ew_state <= EW_TIME;
                        busy <= 1'b1;
                        ew_cnt <= 20'h00000;
                        ptc_edges <= 8'h00;
                        ext_seen <= 1'b0;
                    end
                end
                EW_TIME: begin
                    ew_cnt <= ew_cnt + 20'h00001;
                    // RULE7: external edges take over
                    if (ptc_rise) begin
                        ext_seen <= 1'b1;
                        if (ptc_edges != `EE_PTC_SAT) begin
                            ptc_edges <= ptc_edges + 8'h01;
                        end
                    end
                    if (ew_end) begin
                        ew_state <= EW_COMMIT;
                        idx <= 3'h0;
                    end
                end
                EW_COMMIT: begin
                    idx <= idx + 3'h1;
                    if (idx == `EE_LAST_SLOT) begin
                        ew_state <= EW_IDLE;
                        busy <= 1'b0;
                    end
                end
                default: begin
                    ew_state <= EW_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    // RULE8: store coded word
    always @(posedge CLK_I) begin
        if (mem_we) begin
            mem[{addr[`EE_PAGE_HI:`EE_BLOCK_LO], idx}] <= wr_code;
        end
    end

    // Encoder on the commit slot, corrector on the read address
    ee_ecc u_ecc (
        .wr_byte_i(wbuf[idx]),
        .wr_code_o(wr_code),
        .rd_code_i(mem[addr]),
        .rd_byte_o(rd_byte)
    );

    // Open-drain pin: only ever pulls low
    assign SDA_O = `EE_SDA_LOW;
    assign SDA_OE_B_O = sda_oe_b;
    assign BUSY_O = busy;
endmodule

// ==== rtl/ee_defines.vh ====
// Shared constants for the serial EEPROM slave access logic
`ifndef EE_DEFINES_VH
`define EE_DEFINES_VH

// Selection byte layout and fixed device-type code
`define EE_DEV_TYPE 4'hA
`define EE_SEL_TYPE_HI 7
`define EE_SEL_TYPE_LO 4
`define EE_SEL_CHIP 3
`define EE_SEL_PAGE_HI 2
`define EE_SEL_PAGE_LO 1
`define EE_SEL_RW 0

// Bit positions within a serial frame
`define EE_BIT_FIRST 4'h0
`define EE_BIT_LAST 4'h7
`define EE_BIT_ACK 4'h8

// Memory organisation
`define EE_ADDR_W 10
`define EE_WORDS 1024
`define EE_CODE_W 12
`define EE_UPPER_BIT 9
`define EE_PAGE_HI 9
`define EE_PAGE_LO 8
`define EE_SLOT_HI 2
`define EE_BLOCK_LO 3
`define EE_LAST_SLOT 3'h7

// Timing: clock rate and erase/write cycle times
`define EE_CLK_MHZ 50
`define EE_TEW_INT_US 7000
`define EE_TEW_MIN_US 4000
`define EE_TEW_MAX_US 10000
`define EE_POR_US 10
`define EE_SCL_MAX_KHZ 100
`define EE_PTC_EDGES 8'h20
`define EE_PTC_SAT 8'hFF

// Open-drain data pin level when driven
`define EE_SDA_LOW 1'b0

`endif

// ==== rtl/ee_ecc.v ====
// Single-error-correcting code for stored bytes: encoder and corrector
`timescale 1ns/10ps
`include "ee_defines.vh"

module ee_ecc (
    input wire [7:0] wr_byte_i,
    output wire [11:0] wr_code_o,
    input wire [11:0] rd_code_i,
    output wire [7:0] rd_byte_o
);
    wire [3:0] syn;
    wire [11:0] fixed;

    // Encoder: parity at positions 1,2,4,8, data at the rest
    assign wr_code_o = {wr_byte_i[7:4],
                        wr_byte_i[4] ^ wr_byte_i[5] ^ wr_byte_i[6] ^ wr_byte_i[7],
                        wr_byte_i[3:1],
                        wr_byte_i[1] ^ wr_byte_i[2] ^ wr_byte_i[3] ^ wr_byte_i[7],
                        wr_byte_i[0],
                        wr_byte_i[0] ^ wr_byte_i[2] ^ wr_byte_i[3] ^ wr_byte_i[5]
                            ^ wr_byte_i[6],
                        wr_byte_i[0] ^ wr_byte_i[1] ^ wr_byte_i[3] ^ wr_byte_i[4]
                            ^ wr_byte_i[6]};

    // Syndrome names the failing position, zero when clean
    assign syn[0] = rd_code_i[0] ^ rd_code_i[2] ^ rd_code_i[4] ^ rd_code_i[6]
                  ^ rd_code_i[8] ^ rd_code_i[10];
    assign syn[1] = rd_code_i[1] ^ rd_code_i[2] ^ rd_code_i[5] ^ rd_code_i[6]
                  ^ rd_code_i[9] ^ rd_code_i[10];
    assign syn[2] = rd_code_i[3] ^ rd_code_i[4] ^ rd_code_i[5] ^ rd_code_i[6]
                  ^ rd_code_i[11];
    assign syn[3] = rd_code_i[7] ^ rd_code_i[8] ^ rd_code_i[9] ^ rd_code_i[10]
                  ^ rd_code_i[11];

    // RULE8: flip one bit
    genvar p;
    generate
        for (p = 0; p < `EE_CODE_W; p = p + 1) begin : g_fix
            assign fixed[p] = rd_code_i[p] ^ (syn == (p + 1));
        end
    endgenerate

    // Data bits back out of the corrected word
    assign rd_byte_o = {fixed[11:8], fixed[6:4], fixed[2]};
endmodule

// ==== tb/ee_slave_assertions.sv ====
// Port-level concurrent checks for the serial EEPROM slave
`timescale 1ns/10ps
module ee_slave_assertions #(
    parameter [19:0] T_INT_CYC = 20'h2BC,
    parameter [19:0] T_MIN_CYC = 20'h190,
    parameter [19:0] T_MAX_CYC = 20'h3E8
) (
    input wire CLK_I,
    input wire RST_B_I,
    input wire SCL_I,
    input wire SDA_I,
    input wire SDA_O,
    input wire SDA_OE_B_O,
    input wire WP_I,
    input wire CHIP_ADDR_PIN_I,
    input wire PROG_TIME_CTRL_I,
    input wire BUSY_O
);
    logic [19:0] busy_len;
    logic [3:0] since_stop;
    logic ptc_q;
    logic sda_q;
    logic ptc_seen;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    // Busy length, distance from last stop, external clock seen while busy
    always @(posedge CLK_I) begin
        ptc_q <= PROG_TIME_CTRL_I;
        sda_q <= SDA_I;
        busy_len <= BUSY_O ? busy_len + 20'h1 : 20'h0;
        ptc_seen <= BUSY_O & (ptc_seen | (PROG_TIME_CTRL_I & ~ptc_q));
        if (!RST_B_I || (SCL_I && SDA_I && !sda_q)) begin
            since_stop <= 4'h0;
        end else if (since_stop != 4'hF) begin
            since_stop <= since_stop + 4'h1;
        end
    end
    a_rst_idle:
        assert property ($rose(RST_B_I) |-> (SDA_OE_B_O && !BUSY_O) [*4])
        else $error("outputs not idle after reset");
    a_busy_quiet:
        assert property (BUSY_O |-> SDA_OE_B_O) else $error("line driven while busy");
    a_busy_min:
        assert property ($fell(BUSY_O) |-> busy_len >= T_MIN_CYC)
        else $error("program cycle too short");
    a_busy_max:
        assert property (BUSY_O |-> busy_len <= T_MAX_CYC + 20'h14)
        else $error("program cycle too long");
    a_int_time:
        assert property ($fell(BUSY_O) && !ptc_seen |->
            busy_len >= T_INT_CYC && busy_len <= T_INT_CYC + 20'h14)
        else $error("internal cycle length wrong");
    a_prog_stop:
        assert property ($rose(BUSY_O) |-> since_stop <= 4'hA)
        else $error("program cycle without stop");
    a_drive_fall:
        assert property ($fell(SDA_OE_B_O) |-> !$past(SCL_I, 2))
        else $error("line pulled outside clock low");
    a_bit_hold:
        assert property ($fell(SDA_OE_B_O) |=> !SDA_OE_B_O [*5])
        else $error("driven bit released early");
    a_od_low:
        assert property (!SDA_OE_B_O |-> !SDA_O) else $error("driven level not low");
endmodule

// ==== tb/ee_master_model.sv ====
// Two-wire bus master model; the serial clock stands high between frames
`timescale 1ns/10ps
module ee_master_model (
    input wire clk_i,
    input wire sda_i,
    output logic scl_o = 1'b1,
    output logic sda_o = 1'b1
);
    // Every change lands a small delay after a clock edge
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask
    // Start or repeated start; waits out a late acknowledge release
    task start();
        sda_o = 1'b1;
        step(4);
        scl_o = 1'b1;
        step(4);
        sda_o = 1'b0;
        step(4);
        scl_o = 1'b0;
        step(1);
    endtask
    task stop();
        sda_o = 1'b0;
        step(3);
        scl_o = 1'b1;
        step(4);
        sda_o = 1'b1;
        step(4);
    endtask
    // One bit: four clocks low, four high, wire read mid-high
    // slow serial clock
    task bit_io(input logic b, output logic r);
        sda_o = b;
        step(3);
        scl_o = 1'b1;
        step(2);
        r = sda_i;
        step(2);
        scl_o = 1'b0;
        step(1);
    endtask
    task xfer(input logic [7:0] d, input logic b9, output logic [7:0] q, output logic r9);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(b9, r9);
    endtask
endmodule

// ==== tb/ee_slave_test.sv ====
// Self-checking bench for the serial EEPROM slave
`timescale 1ns/10ps
`include "ee_defines.vh"
module ee_slave_test;
    localparam [19:0] TI = 20'h2BC;
    localparam [19:0] TN = 20'h190;
    localparam [19:0] TX = 20'h3E8;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic wp = 1'b0;
    logic chip = 1'b0;
    logic prog_time_ctrl = 1'b0;
    logic [7:0] q;
    logic nak;
    wire scl, sda_m, sda_oe_b, sda_o, busy, sda_w;
    int n_fail = 0;
    int n_checks = 0;
    // Open-drain wire with pull-up
    assign sda_w = sda_m & (sda_oe_b | sda_o);
    ee_slave #(.T_INT_CYC(TI), .T_MIN_CYC(TN), .T_MAX_CYC(TX)) u_dut (.CLK_I(clk),
        .RST_B_I(rst_b), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE_B_O(sda_oe_b),
        .WP_I(wp), .CHIP_ADDR_PIN_I(chip), .PROG_TIME_CTRL_I(prog_time_ctrl), .BUSY_O(busy));
    ee_master_model u_mst (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));
    task chk(input string nm, input logic [19:0] got, input logic [19:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task sel(input logic [3:0] ty, input logic c, input logic [1:0] pg, input logic rw);
        u_mst.xfer({ty, c, pg, rw}, 1'b1, q, nak);
    endtask
    task wr(input logic [1:0] pg, input logic [7:0] a, d0, input int n, input logic e);
        u_mst.start();
        sel(`EE_DEV_TYPE, chip, pg, 1'b0);
        u_mst.xfer(a, 1'b1, q, nak);
        for (int i = 0; i < n; i++) begin
            u_mst.xfer(8'(d0 + i), 1'b1, q, nak);
            chk("data_nak", nak, e);
        end
        u_mst.stop();
    endtask
    task rd(input logic [1:0] pg, input logic [7:0] a, d0, input int n);
        u_mst.start();
        sel(`EE_DEV_TYPE, chip, pg, 1'b0);
        u_mst.xfer(a, 1'b1, q, nak);
        u_mst.start();
        sel(`EE_DEV_TYPE, chip, pg, 1'b1);
        for (int i = 0; i < n; i++) begin
            u_mst.xfer(8'hFF, i == n - 1, q, nak);
            chk("rd_data", q, 8'(d0 + i));
        end
        u_mst.stop();
    endtask
    // Bounded waits: busy must rise soon, then its length is counted
    task wait_idle(output int n);
        n = 0;
        for (int k = 0; k < 40 && busy !== 1'b1; k++) u_mst.step(1);
        while (busy === 1'b1 && n < 1100) begin
            u_mst.step(1);
            n++;
        end
    endtask
    task t_byte();
        int n;
        wr(2'h1, 8'h35, 8'h5A, 1, 1'b0);
        u_mst.start();
        sel(`EE_DEV_TYPE, chip, 2'h1, 1'b0);
        u_mst.stop();
        chk("poll_nak", nak, 1'b1);
        wait_idle(n);
        wr(2'h0, 8'h35, 8'hC3, 1, 1'b0);
        wait_idle(n);
        chk("int_time", 20'(n >= TI && n <= TI + 20), 20'h1);
        // one stored bit flipped, read must still match
        u_dut.mem[10'h135] = u_dut.mem[10'h135] ^ 12'h010;
        rd(2'h1, 8'h35, 8'h5A, 1);
        rd(2'h0, 8'h35, 8'hC3, 1);
    endtask
    task t_page();
        int n;
        wr(2'h2, 8'h40, 8'h10, 8, 1'b0);
        wait_idle(n);
        chk("page_one_cycle", 20'(n >= TI), 20'h1);
        rd(2'h2, 8'h40, 8'h10, 8);
    endtask
    task t_sel();
        chip = 1'b1;
        u_mst.start();
        sel(`EE_DEV_TYPE, 1'b0, 2'h0, 1'b0);
        chk("chip_miss", nak, 1'b1);
        u_mst.stop();
        u_mst.start();
        sel(`EE_DEV_TYPE, 1'b1, 2'h0, 1'b0);
        chk("chip_hit", nak, 1'b0);
        // reset mid-frame, the address byte then goes unanswered
        rst_b = 1'b0;
        u_mst.step(3);
        rst_b = 1'b1;
        u_mst.xfer(8'h00, 1'b1, q, nak);
        chk("rst_mid_nak", nak, 1'b1);
        u_mst.stop();
        chk("no_data_idle", busy, 1'b0);
        u_mst.start();
        sel(4'hB, 1'b1, 2'h0, 1'b0);
        chk("type_miss", nak, 1'b1);
        u_mst.stop();
        chip = 1'b0;
    endtask
    task t_wp();
        int n;
        wp = 1'b1;
        wr(2'h2, 8'h40, 8'hEE, 1, 1'b1);
        u_mst.step(20);
        chk("wp_no_prog", busy, 1'b0);
        wr(2'h0, 8'h01, 8'h77, 1, 1'b0);
        wait_idle(n);
        wp = 1'b0;
        rd(2'h2, 8'h40, 8'h10, 1);
        rd(2'h0, 8'h01, 8'h77, 1);
    endtask
    // External timing clock: edges every ten clocks while programming
    task t_ptc();
        int n;
        wr(2'h3, 8'h00, 8'h99, 1, 1'b0);
        fork
            wait_idle(n);
            repeat (80) begin
                u_mst.step(5);
                prog_time_ctrl = ~prog_time_ctrl;
            end
        join
        chk("ext_time", 20'(n >= TN - 10 && n <= TN + 20), 20'h1);
        rd(2'h3, 8'h00, 8'h99, 1);
        // Too few external edges: the upper bound ends the cycle
        wr(2'h3, 8'h08, 8'h66, 1, 1'b0);
        fork
            wait_idle(n);
            repeat (20) begin
                u_mst.step(5);
                prog_time_ctrl = ~prog_time_ctrl;
            end
        join
        chk("max_time", 20'(n >= TX && n <= TX + 20), 20'h1);
        rd(2'h3, 8'h08, 8'h66, 1);
    endtask
    task test_done();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        forever #10 clk = ~clk;
    end
    initial begin
        u_mst.step(3);
        rst_b = 1'b1;
        chk("oe_idle", sda_oe_b, 1'b1);
        chk("busy_idle", busy, 1'b0);
        u_mst.step(5);
        t_byte();
        t_page();
        t_sel();
        t_wp();
        t_ptc();
        test_done();
    end
    // Watchdog well beyond the expected run
    initial begin
        #600000;
        n_fail++;
        test_done();
    end
endmodule
// Checker defaults carry the same shortened cycle counts as the bench
bind ee_slave ee_slave_assertions u_chk (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .SCL_I(SCL_I),
    .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_B_O(SDA_OE_B_O), .WP_I(WP_I),
    .CHIP_ADDR_PIN_I(CHIP_ADDR_PIN_I), .PROG_TIME_CTRL_I(PROG_TIME_CTRL_I), .BUSY_O(BUSY_O));
